/* design/sfhs_seq.sv */
// Serial flash host sequencer: register, fast read and page program
// frames in single-line or four-line mode, SPI mode 0.
// Assumes the flash sits on the pins directly and the user side runs
// on clk_sys.
`timescale 1ns/100ps
module sfhs_seq #(
	parameter int         SCK_HALF       = 4,
	parameter int         DUMMY_EXT      = 8,
	parameter int         DUMMY_QUAD     = 10,
	parameter logic [7:0] LOCK_RD_OPCODE = 8'he8,
	parameter logic [7:0] LOCK_WR_OPCODE = 8'he5,
	parameter logic [7:0] NVCR_RD_OPCODE = 8'hb5,
	parameter logic [7:0] NVCR_WR_OPCODE = 8'hb1
) (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               resetn,
	// Command
	input  wire logic               start,
	input  wire sfhs_pkg::sfhs_op_e op,
	input  wire logic               quad,
	input  wire logic [7:0]         opcode,
	input  wire logic [23:0]        addr,
	input  wire logic [8:0]         nbytes,
	input  wire logic [15:0]        reg_wdata,
	// Status
	output logic                    busy,
	output logic                    done,
	output logic                    refused,
	output logic [31:0]             reg_rdata,
	// Data stream
	input  wire logic [7:0]         wr_data,
	input  wire logic               wr_valid,
	output logic                    wr_ready,
	output logic [7:0]              rd_data,
	output logic                    rd_valid,
	// Flash pins
	output logic                    flash_sck,
	output logic                    flash_cs_n,
	output logic [3:0]              flash_io_out,
	output logic [3:0]              flash_io_oe,
	input  wire logic [3:0]         flash_io_in
);
	import sfhs_pkg::*;

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	if (SCK_HALF < 4 || SCK_HALF > 255) begin : g_bad_half
		$error("SCK_HALF must lie in 4..255");
	end
	if (DUMMY_EXT < 1 || DUMMY_EXT > 255 ||
	    DUMMY_QUAD < 1 || DUMMY_QUAD > 255) begin : g_bad_dummy
		$error("Dummy cycle counts must lie in 1..255");
	end

	typedef struct packed {
		sfhs_state_e st;
		sfhs_op_e    op;
		logic        quad;
		logic        nvcr;
		logic        cs_n;
		logic        sck;
		logic [3:0]  dout;
		logic [3:0]  oe;
		logic [31:0] sh;
		logic [23:0] addr;
		logic [15:0] wd;
		logic [7:0]  cnt;
		logic [8:0]  bytes_left;
		logic [15:0] fcyc;
		logic [1:0]  ridx;
		logic [31:0] rbuf;
		logic [31:0] reg_rdata;
		logic [7:0]  rd_data;
		logic        rd_valid;
		logic        wr_ready;
		logic        busy;
		logic        done;
		logic        refused;
	} sfhs_seq_s;

	sfhs_seq_s  r;
	sfhs_seq_s  n;
	logic       tick;
	logic [3:0] din_sync;
	logic [3:0] din;
	logic [7:0] unit_cyc;
	logic       lock_op;
	logic       bad_len;

	// ------------------------------------------------------------
	// Serial clock pacing and input synchronisers
	// ------------------------------------------------------------
	sfhs_tick #(
		.HALF    (SCK_HALF)
	) u_tick (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.run     (r.busy && !r.wr_ready),
		.tick    (tick)
	);

	sfhs_sync #(
		.W       (4)
	) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.pin     (flash_io_in),
		.q       (din_sync)
	);

	// Single-line read data comes back on lane 1
	assign din      = r.quad ? din_sync : {3'b000, din_sync[1]};
	assign unit_cyc = r.quad ? QUAD_BYTE_CYC : EXT_BYTE_CYC;
	assign lock_op  = (op == SFHS_REG_RD && opcode == LOCK_RD_OPCODE) ||
	                  (op == SFHS_REG_WR && opcode == LOCK_WR_OPCODE);
	assign bad_len  = (op != SFHS_REG_WR && nbytes == 9'h000) ||
	                  (op == SFHS_REG_RD && nbytes > 9'(REG_MAX_BYTES));

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		n          = r;
		n.done     = 1'b0;
		n.refused  = 1'b0;
		n.rd_valid = 1'b0;
		case (r.st)
		ST_IDLE: begin
			if (start) begin
				if (lock_op || bad_len) begin
					n.refused = 1'b1;
				end else begin
					n.st         = ST_CMD;
					n.busy       = 1'b1;
					n.cs_n       = 1'b0;
					n.op         = op;
					n.quad       = quad;
					n.sh         = {opcode, 24'h000000};
					n.cnt        = quad ? QUAD_BYTE_CYC : EXT_BYTE_CYC;
					n.addr       = addr;
					n.wd         = reg_wdata;
					n.nvcr       = (op == SFHS_REG_RD) ?
					               (opcode == NVCR_RD_OPCODE) :
					               (opcode == NVCR_WR_OPCODE);
					n.bytes_left = nbytes;
					n.fcyc       = 16'h0000;
					n.ridx       = 2'b00;
					n.rbuf       = 32'h00000000;
				end
			end
		end
		ST_END: begin
			if (tick) begin
				n.st   = ST_IDLE;
				n.cs_n = 1'b1;
				n.busy = 1'b0;
				n.done = 1'b1;
				if (r.op == SFHS_REG_RD) begin
					n.reg_rdata = r.rbuf;
				end
			end
		end
		default: begin
			if (r.wr_ready && wr_valid) begin
				n.sh       = {wr_data, 24'h000000};
				n.wr_ready = 1'b0;
			end else if (tick && !r.sck) begin
				n.sck = 1'b1;
			end else if (tick) begin
				n.sck  = 1'b0;
				n.sh   = r.quad ? {r.sh[27:0], din} : {r.sh[30:0], din[0]};
				n.fcyc = r.fcyc + 16'h0001;
				if (r.cnt != 8'h01) begin
					n.cnt  = r.cnt - 8'h01;
				end else begin
					n.fcyc = r.fcyc;
					case (r.st)
					ST_CMD: begin
						if (r.op == SFHS_REG_RD) begin
							n.st  = ST_RDATA;
							n.cnt = unit_cyc;
						end else if (r.op == SFHS_REG_WR) begin
							n.st  = ST_WDATA;
							n.cnt = r.quad ? QUAD_REGWR_CYC : EXT_REGWR_CYC;
							n.sh  = r.nvcr ?
							        {r.wd[7:0], r.wd[15:8], 16'h0000} :
							        {r.wd, 16'h0000};
						end else begin
							n.st  = ST_ADDR;
							n.cnt = r.quad ? QUAD_ADDR_CYC : EXT_ADDR_CYC;
							n.sh  = {r.addr, 8'h00};
						end
						n.fcyc = r.fcyc + 16'h0001;
					end
					ST_ADDR: begin
						if (r.op == SFHS_FAST_RD) begin
							n.st  = ST_DUMMY;
							n.cnt = r.quad ? 8'(DUMMY_QUAD) : 8'(DUMMY_EXT);
						end else begin
							n.st       = ST_WDATA;
							n.cnt      = unit_cyc;
							n.wr_ready = 1'b1;
						end
						n.fcyc = r.fcyc + 16'h0001;
					end
					ST_DUMMY: begin
						n.st   = ST_RDATA;
						n.cnt  = unit_cyc;
						n.fcyc = r.fcyc + 16'h0001;
					end
					ST_WDATA: begin
						if (r.op == SFHS_PAGE_PROG && r.bytes_left > 9'h001) begin
							n.bytes_left = r.bytes_left - 9'h001;
							n.cnt        = unit_cyc;
							n.wr_ready   = 1'b1;
							n.fcyc       = r.fcyc + 16'h0001;
						end else begin
							n.st = ST_END;
						end
					end
					ST_RDATA: begin
						n.rd_data  = n.sh[7:0];
						n.rd_valid = 1'b1;
						n.ridx     = r.ridx + 2'b01;
						n.rbuf     = r.nvcr ?
						             (r.rbuf | ({24'h000000, n.sh[7:0]} <<
						                        {r.ridx, 3'b000})) :
						             {r.rbuf[23:0], n.sh[7:0]};
						if (r.bytes_left == 9'h001) begin
							n.st = ST_END;
						end else begin
							n.bytes_left = r.bytes_left - 9'h001;
							n.cnt        = unit_cyc;
							n.fcyc       = r.fcyc + 16'h0001;
						end
					end
					default: begin
						n.st = ST_END;
					end
					endcase
				end
			end
		end
		endcase
		// Lane drive follows the phase
		if (n.st == ST_CMD || n.st == ST_ADDR || n.st == ST_WDATA) begin
			n.oe   = n.quad ? 4'hf : 4'h1;
			n.dout = n.quad ? n.sh[31:28] : {3'b000, n.sh[31]};
		end else if (n.st == ST_DUMMY || n.st == ST_RDATA) begin
			n.oe   = n.quad ? 4'h0 : 4'h1;
			n.dout = 4'h0;
		end else begin
			n.oe   = 4'h0;
			n.dout = 4'h0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			r      <= '0;
			r.st   <= ST_IDLE;
			r.op   <= SFHS_REG_RD;
			r.cs_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign busy         = r.busy;
	assign done         = r.done;
	assign refused      = r.refused;
	assign reg_rdata    = r.reg_rdata;
	assign wr_ready     = r.wr_ready;
	assign rd_data      = r.rd_data;
	assign rd_valid     = r.rd_valid;
	assign flash_sck    = r.sck;
	assign flash_cs_n   = r.cs_n;
	assign flash_io_out = r.dout;
	assign flash_io_oe  = r.oe;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	logic [7:0] first_rx;
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			first_rx <= 8'h00;
		end else if (r.rd_valid && r.ridx == 2'b01) begin
			first_rx <= r.rd_data;
		end
	end

	sequence s_last_fall;
		tick && r.sck && r.cnt == 8'h01;
	endsequence
	sequence s_addr_done;
		r.st == ST_ADDR ##0 s_last_fall;
	endsequence

	AST_LOCK_RD: assert property (
		r.st == ST_IDLE && start && op == SFHS_REG_RD &&
		opcode == LOCK_RD_OPCODE |=> refused && flash_cs_n && !busy)
		else $error("Lock register read was issued");
	AST_LOCK_WR: assert property (
		r.st == ST_IDLE && start && op == SFHS_REG_WR &&
		opcode == LOCK_WR_OPCODE |=> refused && flash_cs_n && !busy &&
		r.st == ST_IDLE)
		else $error("Lock register write was issued");
	AST_NVCR_ASM: assert property (
		done && r.op == SFHS_REG_RD && r.nvcr |-> reg_rdata[7:0] == first_rx)
		else $error("Config register read not assembled low byte first");
	AST_NVCR_WR: assert property (
		r.st == ST_WDATA && $past(r.st) == ST_CMD && r.nvcr |->
		(r.quad ? flash_io_out == r.wd[7:4] : flash_io_out[0] == r.wd[7]))
		else $error("Config register write did not start with low byte");
	AST_REGWR_LEN: assert property (
		r.st == ST_WDATA && r.op == SFHS_REG_WR ##0 s_last_fall |->
		r.fcyc == (r.quad ? 16'(REGWR_LAST_QUAD) : 16'(REGWR_LAST_EXT)))
		else $error("Register write frame has the wrong length");
	AST_ADDR_LOAD: assert property (
		r.st == ST_ADDR && $past(r.st) == ST_CMD |->
		r.sh[31:8] == r.addr && flash_io_out[0] == r.addr[23] ||
		r.quad && flash_io_out == r.addr[23:20])
		else $error("Address not sent from bit 23");
	AST_CX_EXT: assert property (
		s_addr_done ##0 !r.quad |-> r.fcyc == 16'(EXT_CX))
		else $error("Single-line address ends at the wrong cycle");
	AST_CX_QUAD: assert property (
		s_addr_done ##0 r.quad |-> r.fcyc == 16'(QUAD_CX))
		else $error("Quad address ends at the wrong cycle");
	AST_FAST_RD: assert property (
		s_addr_done ##0 r.op == SFHS_FAST_RD |=> r.st == ST_DUMMY &&
		flash_io_oe == (r.quad ? 4'h0 : 4'h1))
		else $error("Fast read did not enter dummy phase");
	AST_PAGE_PROG: assert property (
		s_addr_done ##0 r.op == SFHS_PAGE_PROG |=> r.st == ST_WDATA &&
		wr_ready && !flash_sck)
		else $error("Page program did not request data");
	AST_CS_FRAME: assert property (
		$rose(flash_cs_n) |-> $past(r.st) == ST_END && !flash_sck && done)
		else $error("Chip select released outside frame end");

endmodule : sfhs_seq

/* design/sfhs_pkg.sv */
// Shared constants and types for the serial flash host sequencer.
// Assumes a single system clock and a 24-bit addressed serial NOR flash.
package sfhs_pkg;

	// ------------------------------------------------------------
	// Frame geometry
	// ------------------------------------------------------------
	localparam int ADDR_W          = 24;
	localparam int CMD_W           = 8;
	localparam int QUAD_LANES      = 4;
	localparam int EXT_CX_BASE     = 7;
	localparam int QUAD_CX_BASE    = 1;
	localparam int EXT_CX          = EXT_CX_BASE + ADDR_W;
	localparam int QUAD_CX         = QUAD_CX_BASE + ADDR_W / QUAD_LANES;
	localparam int REGWR_LAST_EXT  = 23;
	localparam int REGWR_LAST_QUAD = 5;
	localparam int REG_MAX_BYTES   = 4;

	// ------------------------------------------------------------
	// Cycle counts per phase
	// ------------------------------------------------------------
	localparam logic [7:0] EXT_BYTE_CYC   = 8'(CMD_W);
	localparam logic [7:0] QUAD_BYTE_CYC  = 8'(CMD_W / QUAD_LANES);
	localparam logic [7:0] EXT_ADDR_CYC   = 8'(ADDR_W);
	localparam logic [7:0] QUAD_ADDR_CYC  = 8'(ADDR_W / QUAD_LANES);
	localparam logic [7:0] EXT_REGWR_CYC  = 8'(REGWR_LAST_EXT + 1 - CMD_W);
	localparam logic [7:0] QUAD_REGWR_CYC =
		8'(REGWR_LAST_QUAD + 1 - CMD_W / QUAD_LANES);

	// ------------------------------------------------------------
	// Operations and sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SFHS_REG_RD    = 2'b00,
		SFHS_REG_WR    = 2'b01,
		SFHS_FAST_RD   = 2'b10,
		SFHS_PAGE_PROG = 2'b11
	} sfhs_op_e;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CMD   = 3'b001,
		ST_ADDR  = 3'b010,
		ST_DUMMY = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_END   = 3'b110
	} sfhs_state_e;

endpackage : sfhs_pkg

/* design/sfhs_sync.sv */
// Three-stage input synchroniser for the flash data pins.
// Assumes pins change asynchronously to clk_sys.
`timescale 1ns/100ps
module sfhs_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	// Pins and result
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] q
);
	import sfhs_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sfhs_sync_s;

	sfhs_sync_s   r;
	sfhs_sync_s   n;
	logic [W-1:0] next_q;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (W < 1) begin : g_bad_w
		$error("W must be at least 1");
	end

	// ------------------------------------------------------------
	// A change counts once stages two and three agree
	// ------------------------------------------------------------
	for (genvar i = 0; i < W; i++) begin : g_bit
		assign next_q[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
	end

	always_comb begin
		n    = r;
		n.s1 = pin;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.q  = next_q;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign q = r.q;

endmodule : sfhs_sync

/* design/sfhs_tick.sv */
// Half-period tick generator for the flash serial clock.
// Assumes run stays high for the whole frame except while stalled.
`timescale 1ns/100ps
module sfhs_tick #(
	parameter int HALF = 4
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Control
	input  wire logic run,
	output logic      tick
);
	import sfhs_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} sfhs_tick_s;

	sfhs_tick_s r;
	sfhs_tick_s n;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (HALF < 1 || HALF > 256) begin : g_bad_half
		$error("HALF must lie in 1..256");
	end

	// ------------------------------------------------------------
	// Counter restarts whenever run drops
	// ------------------------------------------------------------
	always_comb begin
		n      = r;
		n.tick = 1'b0;
		if (!run) begin
			n.cnt = 8'h00;
		end else if (r.cnt == 8'(HALF - 1)) begin
			n.cnt  = 8'h00;
			n.tick = 1'b1;
		end else begin
			n.cnt = r.cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign tick = r.tick;

endmodule : sfhs_tick

/* test/sfhs_flash_model.sv */
// Behavioural serial NOR flash facing the sequencer pins.
// Assumes mode 0 framing; the bench gives the frame shape in the same cycle as start.
`timescale 1ns/100ps
module sfhs_flash_model (
	// Flash pins
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic [3:0]  io,
	output logic      [3:0]  drv,
	// Frame shape from the bench
	input  wire logic        quad,
	input  wire logic [7:0]  cap_n,
	input  wire logic [7:0]  rd_from,
	input  wire logic [31:0] rd_word,
	// Observed frame
	output logic      [63:0] cap,
	output logic      [7:0]  ncyc
);
	logic [7:0] u;
	logic [7:0] b;

	initial begin
		drv  = 4'h0;
		cap  = '0;
		ncyc = '0;
	end

	// ----------------------------------------------------------------
	// Frame boundaries
	// ----------------------------------------------------------------
	always @(negedge cs_n) begin
		cap  = '0;
		ncyc = '0;
	end
	// Released lanes show the inverse of the last value
	always @(posedge cs_n) drv = ~drv;

	// ----------------------------------------------------------------
	// Sampling and read data
	// ----------------------------------------------------------------
	// Command, address and write data taken on the rise
	always @(posedge sck) if (!cs_n) begin
		if (ncyc < cap_n)
			cap = quad ? {cap[59:0], io} : {cap[62:0], io[0]};
		ncyc = ncyc + 8'h01;
	end
	// Data launched on the fall, low byte first
	always @(negedge sck) begin
		u = ncyc - rd_from;
		b = rd_word[8 * (quad ? u[2:1] : u[4:3]) +: 8];
		if (!cs_n && ncyc >= rd_from)
			drv = quad ? (u[0] ? b[3:0] : b[7:4])
				: {~drv[3:2], b[3'd7 - u[2:0]], ~drv[0]};
		else
			drv = ~drv;
	end
endmodule : sfhs_flash_model

/* test/tb_sfhs_seq.sv */
// Self-checking bench for the serial flash host sequencer.
// Assumes the behavioural flash model and default serial clock divider.
`timescale 1ns/100ps
module tb_sfhs_seq;
	import sfhs_pkg::*;
	localparam logic [7:0]  RD_LOCK = 8'he8;
	localparam logic [7:0]  WR_LOCK = 8'he5;
	localparam logic [7:0]  RD_CFG  = 8'hb5;
	localparam logic [7:0]  WR_CFG  = 8'hb1;
	localparam logic [31:0] RD_WORD = 32'h96a53ce1;
	localparam logic [23:0] ADR     = 24'hc35a96;
	logic        clk_sys = 1'b0;
	logic        resetn, start, quad, busy, done, refused;
	sfhs_op_e    op;
	logic [7:0]  opcode, wr_data, rd_data, cap_n, rd_from, ncyc;
	logic [23:0] addr;
	logic [8:0]  nbytes;
	logic [15:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        wr_valid, wr_ready, rd_valid, flash_sck, flash_cs_n;
	logic [3:0]  flash_io_out, flash_io_oe, flash_io_in, drv;
	logic [63:0] cap;
	int          errors = 0;
	int          checked = 0;
	logic [7:0]  rq[$];

	always #2.5 clk_sys = ~clk_sys;
	assign flash_io_in = (flash_io_oe & flash_io_out) | (~flash_io_oe & drv);

	sfhs_seq #(.LOCK_RD_OPCODE(RD_LOCK), .LOCK_WR_OPCODE(WR_LOCK),
		.NVCR_RD_OPCODE(RD_CFG), .NVCR_WR_OPCODE(WR_CFG)) dut (
		.clk_sys(clk_sys), .resetn(resetn), .start(start), .op(op),
		.quad(quad), .opcode(opcode), .addr(addr), .nbytes(nbytes),
		.reg_wdata(reg_wdata), .busy(busy), .done(done),
		.refused(refused), .reg_rdata(reg_rdata), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .flash_sck(flash_sck),
		.flash_cs_n(flash_cs_n), .flash_io_out(flash_io_out),
		.flash_io_oe(flash_io_oe), .flash_io_in(flash_io_in));

	sfhs_flash_model flash (.sck(flash_sck), .cs_n(flash_cs_n),
		.io(flash_io_in), .drv(drv), .quad(quad), .cap_n(cap_n),
		.rd_from(rd_from), .rd_word(RD_WORD), .cap(cap), .ncyc(ncyc));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One frame: start, feed or collect bytes, then judge the frame
	task automatic run(input sfhs_op_e o, input logic q,
		input logic [7:0] opc, input logic [8:0] nb, input logic [15:0] wd,
		input logic [7:0] cn, input logic [7:0] rf, input logic ref_exp,
		input logic [7:0] ecyc, input logic [63:0] ecap, input int nrd);
		int  st;
		int  wk;
		logic fin;
		logic take;
		rq.delete();
		fin = 1'b0;
		st = 0;
		wk = 0;
		@(posedge clk_sys);
		start <= 1'b1;
		op <= o;
		quad <= q;
		opcode <= opc;
		addr <= ADR;
		nbytes <= nb;
		reg_wdata <= wd;
		cap_n <= cn;
		rd_from <= rf;
		@(posedge clk_sys);
		start <= 1'b0;
		@(negedge clk_sys);
		chk("refused", refused, ref_exp);
		chk("select", flash_cs_n, ref_exp);
		chk("busy", busy, !ref_exp);
		if (ref_exp)
			return;
		chk("lanes", flash_io_oe, q ? 4'hf : 4'h1);
		for (int i = 0; i < 3000 && !fin; i++) begin
			@(negedge clk_sys);
			if (rd_valid)
				rq.push_back(rd_data);
			fin = done;
			take = wr_valid && wr_ready;
			if (fin) begin
				chk("release", flash_cs_n, 1);
				chk("end busy", busy, 0);
				chk("end lanes", flash_io_oe, 0);
			end
			@(posedge clk_sys);
			if (take) begin
				wr_valid <= 1'b0;
				wk++;
				st = 0;
			end else if (wr_ready && !wr_valid) begin
				if (st == 3) begin
					wr_valid <= 1'b1;
					wr_data <= 8'ha0 + 8'(wk);
				end
				st++;
			end
		end
		if (!fin) begin
			errors++;
			$display("BAD done expected 1 seen 0");
			summarize();
		end
		chk("cycles", ncyc, ecyc);
		chk("frame", cap, ecap);
		chk("rd count", rq.size(), nrd);
		for (int k = 0; k < nrd && k < rq.size(); k++)
			chk("rd byte", rq[k], RD_WORD[8 * (k % 4) +: 8]);
	endtask : run

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reg_rd();
		logic [7:0]  opc;
		logic [8:0]  nb;
		for (int m = 0; m < 4; m++) begin
			opc = m[1] ? RD_CFG : 8'h05;
			nb = m[1] ? 9'd4 : 9'd2;
			run(SFHS_REG_RD, m[0], opc, nb, 16'h0, m[0] ? 8'd2 : 8'd8,
				m[0] ? 8'd2 : 8'd8, 1'b0,
				m[0] ? 8'(2 + 2 * nb) : 8'(8 + 8 * nb), 64'(opc), nb);
			chk("reg_rdata", reg_rdata,
				m[1] ? RD_WORD : 32'h0000e13c);
		end
	endtask : t_reg_rd

	task automatic t_refuse();
		run(SFHS_REG_RD, 1'b0, RD_LOCK, 9'd2, 16'h0, 8'h00, 8'h00, 1'b1,
			8'h00, 64'h0, 0);
		run(SFHS_REG_WR, 1'b1, WR_LOCK, 9'd2, 16'h0, 8'h00, 8'h00, 1'b1,
			8'h00, 64'h0, 0);
		run(SFHS_FAST_RD, 1'b0, 8'h0b, 9'd0, 16'h0, 8'h00, 8'h00, 1'b1,
			8'h00, 64'h0, 0);
		run(SFHS_REG_RD, 1'b1, 8'h05, 9'd5, 16'h0, 8'h00, 8'h00, 1'b1,
			8'h00, 64'h0, 0);
	endtask : t_refuse

	// Reset in mid-frame returns the pins to idle
	task automatic t_mid_reset();
		@(posedge clk_sys);
		start <= 1'b1;
		op <= SFHS_FAST_RD;
		nbytes <= 9'd1;
		@(posedge clk_sys);
		start <= 1'b0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b0;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		@(negedge clk_sys);
		chk("reset select", flash_cs_n, 1);
		chk("reset busy", busy, 0);
		chk("reset lanes", flash_io_oe, 0);
		chk("reset clock", flash_sck, 0);
	endtask : t_mid_reset

	task automatic t_reg_wr();
		logic [7:0] opc;
		for (int m = 0; m < 4; m++) begin
			opc = m[1] ? WR_CFG : 8'h01;
			run(SFHS_REG_WR, m[0], opc, 9'd0, 16'h1234, m[0] ? 8'd6 : 8'd24,
				8'hff, 1'b0, m[0] ? 8'd6 : 8'd24,
				m[1] ? 64'({opc, 16'h3412}) : 64'({opc, 16'h1234}),
				0);
		end
	endtask : t_reg_wr

	task automatic t_fast_rd();
		for (int q = 0; q < 2; q++)
			run(SFHS_FAST_RD, q[0], 8'h0b, 9'd5, 16'h0, q ? 8'd8 : 8'd32,
				q ? 8'd18 : 8'd40, 1'b0, q ? 8'd28 : 8'd80,
				64'({8'h0b, ADR}), 5);
	endtask : t_fast_rd

	task automatic t_page_prog();
		for (int q = 0; q < 2; q++)
			run(SFHS_PAGE_PROG, q[0], 8'h02, 9'd2, 16'h0, q ? 8'd12 : 8'd48,
				8'hff, 1'b0, q ? 8'd12 : 8'd48,
				64'({8'h02, ADR, 16'ha0a1}), 0);
	endtask : t_page_prog

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		start = 1'b0;
		op = SFHS_REG_RD;
		quad = 1'b0;
		opcode = 8'h00;
		addr = 24'h000000;
		nbytes = 9'h000;
		reg_wdata = 16'h0000;
		wr_data = 8'h00;
		wr_valid = 1'b0;
		cap_n = 8'h00;
		rd_from = 8'hff;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		@(negedge clk_sys);
		chk("idle select", flash_cs_n, 1);
		chk("idle clock", flash_sck, 0);
		t_reg_rd();
		t_refuse();
		t_reg_wr();
		t_fast_rd();
		t_mid_reset();
		t_page_prog();
		summarize();
	end
endmodule : tb_sfhs_seq
